// *** rtl/dtw_dram_ctrl.sv ***
// Area 2 DRAM controller: register file, refresh timer and RAS/CAS sequencer.
// Assumes a CPU-side master holding cpuReq until cpuAck and an Avalon master.
//
// The Avalon-MM register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
module dtw_dram_ctrl (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // Avalon-MM register slave
    input wire logic [5:0] avsAddress,
    input wire logic avsRead,
    input wire logic avsWrite,
    input wire logic [31:0] avsWritedata,
    input wire logic [3:0] avsByteenable,
    output logic [31:0] avsReaddata,
    output logic avsWaitrequest,
    // CPU memory request port
    input wire logic cpuReq,
    input wire dtw_pkg::dtw_cpu_req_t cpuCmd,
    output logic cpuAck,
    output logic [15:0] cpuRdata,
    // DRAM pins
    output dtw_pkg::dtw_pins_t dramPins,
    input wire logic [15:0] dqIn,
    // Compare match event
    output logic cmIrq
);
    import dtw_pkg::*;

    logic [7:0] cfg [DTW_NUM_REGS];
    logic [7:0] next_cfg [DTW_NUM_REGS];
    logic next_avsWaitrequest;
    logic [31:0] next_avsReaddata;
    logic [11:0] presc, next_presc;
    logic [7:0] refCount, next_refCount;
    logic refPend, next_refPend;
    logic next_cmIrq;
    dtw_state_t state, next_state;
    dtw_cpu_req_t curCmd, next_curCmd;
    logic [1:0] waitCnt, next_waitCnt;
    logic preCnt, next_preCnt;
    logic rowOpen, next_rowOpen;
    logic [23:0] openRow, next_openRow;
    logic next_cpuAck;
    logic [15:0] next_cpuRdata;
    dtw_pins_t next_pins;

    // -----------------------------------------------------------------
    // Decoded configuration
    // -----------------------------------------------------------------
    logic [3:0] regIdx;
    logic regValid, busWrite, tick, match, refTaken;
    logic dramArea2, width16, part2M, longPre, burst, rasDown, weCtrl;
    logic [1:0] waitSel, refWaits, laneEn;
    logic [4:0] rowShift;
    logic [2:0] areaNum;
    logic hit, go;
    logic [23:0] reqRow;

    assign regIdx = avsAddress[5:2];
    assign regValid = (avsAddress[1:0] == 2'h0) && (int'(regIdx) < DTW_NUM_REGS);
    assign busWrite = avsWrite && !avsWaitrequest && avsByteenable[0];
    assign dramArea2 = cfg[REG_BUS_CTRL_HIGH][DRAM_SPACE_LSB +: 3] == DRAM_SPACE_AREA2;
    assign width16 = !cfg[REG_BUS_WIDTH][AREA2_WIDTH_BIT];
    assign part2M = cfg[REG_BUS_CTRL_LOW][PARTITION_BIT];
    assign waitSel = cfg[REG_WAIT_LOW][AREA2_WAIT_LSB +: 2];
    assign longPre = cfg[REG_MEM_CTRL][PRECHARGE_BIT];
    assign burst = cfg[REG_MEM_CTRL][BURST_BIT];
    assign rasDown = cfg[REG_MEM_CTRL][RAS_DOWN_BIT];
    assign weCtrl = cfg[REG_MEM_CTRL][WE_CTRL_BIT];
    assign rowShift = ROW_SHIFT_BASE + {3'h0, cfg[REG_MEM_CTRL][MUX_LSB +: 2]};
    // No refresh waits unless insertion is enabled
    assign refWaits = cfg[REG_DRAM_CTRL][REF_WAIT_INS_BIT] ? cfg[REG_MEM_CTRL][REF_WAIT_LSB +: 2] : 2'h0;
    // Area number from the partition unit; 2-Mbyte units give 0x400000 upward
    assign areaNum = part2M ? cpuCmd.addr[AREA_2M_LSB +: 3] : cpuCmd.addr[AREA_128K_LSB +: 3];
    assign hit = dramArea2 && (areaNum == AREA2_CODE);
    assign go = cpuReq && !cpuAck && hit;
    assign reqRow = cpuCmd.addr >> rowShift;
    // Byte lanes; an 8-bit area uses the low lane only
    assign laneEn = width16 ? next_curCmd.byteEn : 2'h1;

    // -----------------------------------------------------------------
    // Avalon slave: one wait cycle, then the answer
    // -----------------------------------------------------------------
    always_comb begin
        next_avsWaitrequest = 1'b1;
        next_avsReaddata = avsReaddata;
        if ((avsRead || avsWrite) && avsWaitrequest) begin
            next_avsWaitrequest = 1'b0;
            next_avsReaddata = regValid ? {24'h0, cfg[regIdx]} : 32'h0;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            avsWaitrequest <= 1'b1;
            avsReaddata <= 32'h0;
        end else begin
            avsWaitrequest <= next_avsWaitrequest;
            avsReaddata <= next_avsReaddata;
        end
    end

    // -----------------------------------------------------------------
    // Register file; match flag set beats a software clear
    // -----------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < DTW_NUM_REGS; i++) begin
            next_cfg[i] = cfg[i];
            if (busWrite && regValid && int'(regIdx) == i) begin
                next_cfg[i] = avsWritedata[7:0];
            end
        end
        // Flag can only be cleared by software, writing one keeps it
        if (busWrite && regValid && int'(regIdx) == REG_DRAM_CTRL) begin
            next_cfg[REG_DRAM_CTRL][MATCH_FLAG_BIT] = cfg[REG_DRAM_CTRL][MATCH_FLAG_BIT]
                & avsWritedata[MATCH_FLAG_BIT];
        end
        if (match) begin
            next_cfg[REG_DRAM_CTRL][MATCH_FLAG_BIT] = 1'b1;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < DTW_NUM_REGS; i++) begin
                cfg[i] <= DTW_REG_RESET[i];
            end
        end else begin
            for (int i = 0; i < DTW_NUM_REGS; i++) begin
                cfg[i] <= next_cfg[i];
            end
        end
    end

    // -----------------------------------------------------------------
    // Refresh timer: prescaler, counter, compare and request
    // -----------------------------------------------------------------
    assign tick = (cfg[REG_DRAM_CTRL][CKS_LSB +: 3] != 3'h0)
        && ((presc & DTW_CKS_MASK[cfg[REG_DRAM_CTRL][CKS_LSB +: 3]]) == DTW_CKS_MASK[cfg[REG_DRAM_CTRL][CKS_LSB +: 3]]);
    assign match = tick && (refCount == cfg[REG_REFRESH_CONST]);

    always_comb begin
        next_presc = presc + 12'h001;
        next_refCount = refCount;
        if (match) begin
            next_refCount = 8'h00;
        end else if (tick) begin
            next_refCount = refCount + 8'h01;
        end
        next_refPend = refPend && !refTaken;
        // Automatic refresh only; self-refresh mode requests nothing
        if (match && cfg[REG_DRAM_CTRL][REF_EN_BIT] && !cfg[REG_DRAM_CTRL][REF_MODE_BIT]) begin
            next_refPend = 1'b1;
        end
        // Masked match still sets the flag, only the line stays low
        next_cmIrq = cfg[REG_DRAM_CTRL][MATCH_FLAG_BIT] && cfg[REG_DRAM_CTRL][MATCH_IRQ_EN_BIT];
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            presc <= 12'h000;
            refCount <= 8'h00;
            refPend <= 1'b0;
            cmIrq <= 1'b0;
        end else begin
            presc <= next_presc;
            refCount <= next_refCount;
            refPend <= next_refPend;
            cmIrq <= next_cmIrq;
        end
    end

    // -----------------------------------------------------------------
    // Access sequencer
    // -----------------------------------------------------------------
    // Refresh outranks a new access so the request never starves
    always_comb begin
        next_state = state;
        next_curCmd = curCmd;
        next_waitCnt = waitCnt;
        next_rowOpen = rowOpen;
        next_openRow = openRow;
        next_cpuAck = 1'b0;
        next_cpuRdata = cpuRdata;
        refTaken = 1'b0;
        unique case (state)
            ST_IDLE: begin
                if (cpuAck) begin
                    next_state = ST_IDLE;
                end else if (rowOpen) begin
                    if (refPend) begin
                        next_state = ST_PRE;
                    end else if (go && reqRow == openRow) begin
                        next_state = ST_COL1;
                        next_curCmd = cpuCmd;
                        next_waitCnt = waitSel;
                    end else if (go || !rasDown) begin
                        next_state = ST_PRE;
                    end else if (cpuReq) begin
                        // Other areas pass while the row stays down
                        next_cpuAck = 1'b1;
                        next_cpuRdata = 16'h0000;
                    end
                end else if (refPend) begin
                    next_state = ST_RPRE;
                    refTaken = 1'b1;
                end else if (go) begin
                    next_state = ST_ROW;
                    next_curCmd = cpuCmd;
                    next_openRow = reqRow;
                    next_rowOpen = 1'b1;
                    next_waitCnt = waitSel;
                end else if (cpuReq) begin
                    // Other areas are not this block's; answer at once
                    next_cpuAck = 1'b1;
                    next_cpuRdata = 16'h0000;
                end
            end
            ST_ROW: next_state = ST_COL1;
            ST_COL1: next_state = (waitCnt != 2'h0) ? ST_WAIT : ST_COL2;
            ST_WAIT: begin
                next_waitCnt = waitCnt - 2'h1;
                next_state = (waitCnt == 2'h1) ? ST_COL2 : ST_WAIT;
            end
            ST_COL2: begin
                next_cpuAck = 1'b1;
                next_cpuRdata = dqIn;
                // Row stays open for page hits in burst or RAS down mode
                next_state = (burst || rasDown) ? ST_IDLE : ST_PRE;
            end
            ST_PRE: begin
                next_rowOpen = 1'b0;
                next_state = (preCnt == 1'b0) ? ST_IDLE : ST_PRE;
            end
            ST_RPRE: next_state = ST_RCAS;
            ST_RCAS: begin
                next_state = ST_RRAS;
                next_waitCnt = refWaits;
            end
            ST_RRAS: begin
                next_waitCnt = waitCnt - 2'h1;
                next_state = (waitCnt == 2'h0) ? ST_RHOLD : ST_RRAS;
            end
            ST_RHOLD: next_state = ST_PRE;
        endcase
        // Precharge length: one state, or two when the bit is set
        next_preCnt = preCnt - 1'b1;
        if (next_state == ST_PRE && state != ST_PRE) begin
            next_preCnt = longPre;
        end else if (state != ST_PRE) begin
            next_preCnt = 1'b0;
        end
    end

    // Pin values follow the next state so they line up with it
    always_comb begin
        logic active, colPhase, refCas;
        active = next_state inside {ST_ROW, ST_COL1, ST_WAIT, ST_COL2};
        colPhase = next_state inside {ST_COL1, ST_WAIT, ST_COL2};
        refCas = next_state inside {ST_RCAS, ST_RRAS, ST_RHOLD};
        next_pins = dramPins;
        // RAS low while a row is open or in the refresh RAS and hold states; high in precharge
        next_pins.rasN = !(active || next_state inside {ST_RRAS, ST_RHOLD}
            || (next_state == ST_IDLE && next_rowOpen));
        next_pins.casHiN = !(refCas || (colPhase && (weCtrl || laneEn[1])));
        next_pins.casLoN = !(refCas || (colPhase && (weCtrl || laneEn[0])));
        // Two write strobes in 2-WE mode, one common strobe otherwise
        next_pins.weHiN = !(active && next_curCmd.write && (!weCtrl || next_curCmd.byteEn[1] && width16));
        next_pins.weLoN = !(active && next_curCmd.write && (!weCtrl || next_curCmd.byteEn[0] || !width16));
        if (next_state == ST_ROW) begin
            next_pins.addr = next_openRow;
        end else if (colPhase) begin
            next_pins.addr = next_curCmd.addr;
        end
        next_pins.dqOut = next_curCmd.wdata;
        next_pins.dqOe = colPhase && next_curCmd.write;
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            state <= ST_IDLE;
            curCmd <= '0;
            waitCnt <= 2'h0;
            preCnt <= 1'b0;
            rowOpen <= 1'b0;
            openRow <= 24'h0;
            cpuAck <= 1'b0;
            cpuRdata <= 16'h0000;
            dramPins <= '{rasN: 1'b1, casHiN: 1'b1, casLoN: 1'b1, weHiN: 1'b1, weLoN: 1'b1,
                addr: 24'h0, dqOut: 16'h0, dqOe: 1'b0};
        end else begin
            state <= next_state;
            curCmd <= next_curCmd;
            waitCnt <= next_waitCnt;
            preCnt <= next_preCnt;
            rowOpen <= next_rowOpen;
            openRow <= next_openRow;
            cpuAck <= next_cpuAck;
            cpuRdata <= next_cpuRdata;
            dramPins <= next_pins;
        end
    end

    // -----------------------------------------------------------------
    // Checks
    // -----------------------------------------------------------------
    a_wait_one_state: assert property (@(posedge mclk) disable iff (reset)
        (state == ST_COL1 && waitCnt == 2'h1) |=> state == ST_WAIT ##1 state == ST_COL2)
        else $error("wait state count wrong");
    a_ref_precharge_first: assert property (@(posedge mclk) disable iff (reset)
        (state == ST_RCAS) |-> $past(state == ST_RPRE) && dramPins.rasN && !dramPins.casLoN)
        else $error("refresh CAS without precharge");
    a_cas_before_ras: assert property (@(posedge mclk) disable iff (reset)
        $fell(dramPins.rasN) && state == ST_RRAS |-> $past(!dramPins.casLoN && !dramPins.casHiN))
        else $error("RAS fell before CAS in refresh");
    a_post_ref_precharge: assert property (@(posedge mclk) disable iff (reset)
        (state == ST_RHOLD) |=> state == ST_PRE && dramPins.rasN)
        else $error("no precharge after refresh");
    a_single_precharge: assert property (@(posedge mclk) disable iff (reset)
        $rose(state == ST_PRE) && !longPre |=> state != ST_PRE && dramPins.rasN)
        else $error("precharge length wrong");
    a_ras_up_close: assert property (@(posedge mclk) disable iff (reset)
        (state == ST_IDLE && rowOpen && !rasDown && !cpuAck && !cpuReq) |=> state == ST_PRE)
        else $error("row left open in RAS up mode");
    a_match_sets_flag: assert property (@(posedge mclk) disable iff (reset)
        match |=> cfg[REG_DRAM_CTRL][MATCH_FLAG_BIT] && refCount == 8'h00)
        else $error("match did not set flag");
    a_masked_irq: assert property (@(posedge mclk) disable iff (reset)
        !cfg[REG_DRAM_CTRL][MATCH_IRQ_EN_BIT] |=> !cmIrq)
        else $error("interrupt raised while masked");
    a_row_address: assert property (@(posedge mclk) disable iff (reset)
        (state == ST_ROW) |-> dramPins.addr == (curCmd.addr >> rowShift) && !dramPins.rasN)
        else $error("row address not shifted");
    a_we_lane_gate: assert property (@(posedge mclk) disable iff (reset)
        (state == ST_COL1 && weCtrl && curCmd.write && !curCmd.byteEn[1]) |-> dramPins.weHiN)
        else $error("upper write strobe without lane");
endmodule : dtw_dram_ctrl

// *** rtl/dtw_pkg.sv ***
// Constants, register map and carrier types for the area 2 DRAM controller.
// Assumes one 100 MHz clock; register offsets are word aligned Avalon bytes.
//
// Notes on behaviour
// - Run advanced mode four, 16-bit external bus.
// - Space select code one makes area 2 DRAM.
// - Area 2 width bit zero means 16-bit.
// - 2-Mbyte partition puts DRAM at 0x400000.
// - Wait field 01 adds one wait state.
// - Write-strobe bit one: per-lane write enables.
// - Burst bit one: fast page, RAS held.
// - RAS down holds row; RAS up closes it.
// - Refresh wait field 00 adds no wait.
// - Refresh enabled, mode zero: automatic CBR refresh.
// - Counter match with constant requests a refresh.
// - Precharge, then CAS before RAS.
// - Precharge after refresh before next access.
// - Clock select 001 counts at half rate.
package dtw_pkg;
    // -----------------------------------------------------------------
    // Register map (byte offsets, register index = offset / 4)
    // -----------------------------------------------------------------
    localparam int DTW_NUM_REGS = 9;
    localparam int REG_BUS_WIDTH = 0;
    localparam int REG_ACCESS_STATE = 1;
    localparam int REG_WAIT_HIGH = 2;
    localparam int REG_WAIT_LOW = 3;
    localparam int REG_BUS_CTRL_HIGH = 4;
    localparam int REG_BUS_CTRL_LOW = 5;
    localparam int REG_MEM_CTRL = 6;
    localparam int REG_DRAM_CTRL = 7;
    localparam int REG_REFRESH_CONST = 8;
    localparam logic [7:0] DTW_REG_RESET [DTW_NUM_REGS] = '{
        8'h00, 8'hff, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff};
    // -----------------------------------------------------------------
    // Field positions
    // -----------------------------------------------------------------
    localparam int AREA2_WIDTH_BIT = 2;
    localparam int AREA2_WAIT_LSB = 4;
    localparam int DRAM_SPACE_LSB = 0;
    localparam logic [2:0] DRAM_SPACE_AREA2 = 3'h1;
    localparam int PARTITION_BIT = 2;
    localparam int PRECHARGE_BIT = 7;
    localparam int BURST_BIT = 6;
    localparam int RAS_DOWN_BIT = 5;
    localparam int WE_CTRL_BIT = 4;
    localparam int MUX_LSB = 2;
    localparam int REF_WAIT_LSB = 0;
    localparam int REF_EN_BIT = 7;
    localparam int REF_WAIT_INS_BIT = 6;
    localparam int REF_MODE_BIT = 5;
    localparam int MATCH_FLAG_BIT = 4;
    localparam int MATCH_IRQ_EN_BIT = 3;
    localparam int CKS_LSB = 0;
    // -----------------------------------------------------------------
    // Address decode and multiplex
    // -----------------------------------------------------------------
    localparam logic [2:0] AREA2_CODE = 3'h2;
    localparam int AREA_2M_LSB = 21;
    localparam int AREA_128K_LSB = 17;
    localparam logic [4:0] ROW_SHIFT_BASE = 5'h08;
    // Prescaler masks per clock select; 001 ticks every second clock
    localparam logic [11:0] DTW_CKS_MASK [8] = '{
        12'h000, 12'h001, 12'h007, 12'h01f, 12'h07f, 12'h1ff, 12'h7ff, 12'hfff};
    // -----------------------------------------------------------------
    // Types
    // -----------------------------------------------------------------
    typedef enum logic [9:0] {
        ST_IDLE = 10'h001, ST_ROW = 10'h002, ST_COL1 = 10'h004, ST_WAIT = 10'h008,
        ST_COL2 = 10'h010, ST_PRE = 10'h020, ST_RPRE = 10'h040, ST_RCAS = 10'h080,
        ST_RRAS = 10'h100, ST_RHOLD = 10'h200
    } dtw_state_t;
    typedef struct packed {
        logic write;
        logic [23:0] addr;
        logic [15:0] wdata;
        logic [1:0] byteEn;
    } dtw_cpu_req_t;
    typedef struct packed {
        logic rasN;
        logic casHiN;
        logic casLoN;
        logic weHiN;
        logic weLoN;
        logic [23:0] addr;
        logic [15:0] dqOut;
        logic dqOe;
    } dtw_pins_t;
endpackage : dtw_pkg

// *** tb/dtw_dram_model.sv ***
// Behavioural x16 DRAM for the area 2 controller bench.
// Assumes the controller's registered pin struct and one shared clock.
`timescale 1ns/1ps
module dtw_dram_model (
    // Clock
    input wire logic mclk,
    // Controller pins and read data back
    input wire dtw_pkg::dtw_pins_t pins,
    output logic [15:0] dqIn
);
    import dtw_pkg::*;
    logic [15:0] mem [256];
    logic [7:0] col;
    logic [15:0] last = 16'h0000;
    // Word index from the column address bits above the byte bit
    assign col = pins.addr[8:1];
    // Each lane is written only under its own write strobe
    always @(posedge mclk) begin
        if (!pins.rasN && !pins.casLoN && !pins.weLoN) mem[col][7:0] <= pins.dqOut[7:0];
        if (!pins.rasN && !pins.casHiN && !pins.weHiN) mem[col][15:8] <= pins.dqOut[15:8];
        if (!pins.rasN && !pins.casLoN && pins.weLoN) last <= mem[col];
    end
    // Released lines show the inverse of the last word so stale data never passes
    assign dqIn = (!pins.rasN && !pins.casLoN && pins.weLoN) ? mem[col] : ~last;
endmodule : dtw_dram_model

// *** tb/dtw_dram_ctrl_tb_top.sv ***
// Self-checking bench for the area 2 DRAM controller.
// Assumes the DRAM model beside it and a 100 MHz clock.
`timescale 1ns/1ps
module dtw_dram_ctrl_tb_top;
    import dtw_pkg::*;
    logic mclk = 0, reset = 1, avsRead = 0, avsWrite = 0, cpuReq = 0, avsWaitrequest, cpuAck, cmIrq;
    logic [5:0] avsAddress = 6'h00;
    logic [31:0] avsWritedata = 32'h0, avsReaddata, rd;
    logic [3:0] avsByteenable = 4'hf;
    dtw_cpu_req_t cpuCmd = '0;
    logic [15:0] cpuRdata, dqIn, cd;
    dtw_pins_t dramPins, prevPins;
    logic [23:0] rowSeen, colSeen;
    logic [1:0] weSeen;
    int n_errors = 0, check_count = 0, cyc = 0, lat, refT[$], badPre = 0;
    // -----------------------------------------------------------------
    // Clock, design and far side
    // -----------------------------------------------------------------
    always #5 mclk = ~mclk;
    dtw_dram_ctrl dut (.mclk(mclk), .reset(reset), .avsAddress(avsAddress), .avsRead(avsRead),
        .avsWrite(avsWrite), .avsWritedata(avsWritedata), .avsByteenable(avsByteenable),
        .avsReaddata(avsReaddata), .avsWaitrequest(avsWaitrequest), .cpuReq(cpuReq), .cpuCmd(cpuCmd),
        .cpuAck(cpuAck), .cpuRdata(cpuRdata), .dramPins(dramPins), .dqIn(dqIn), .cmIrq(cmIrq));
    dtw_dram_model far (.mclk(mclk), .pins(dramPins), .dqIn(dqIn));
    // Pin monitor: row on RAS fall, column and strobes on CAS fall, refresh starts
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        prevPins <= dramPins;
        if (prevPins.rasN && !dramPins.rasN && dramPins.casLoN) rowSeen <= dramPins.addr;
        if (prevPins.casLoN && !dramPins.casLoN && !dramPins.rasN) begin
            colSeen <= dramPins.addr;
            weSeen <= {dramPins.weHiN, dramPins.weLoN};
        end
        if (!reset && prevPins.casLoN && !dramPins.casLoN && dramPins.rasN) begin
            refT.push_back(cyc);
            if (!(prevPins.rasN && prevPins.casHiN)) badPre <= badPre + 1;
        end
    end
    // -----------------------------------------------------------------
    // Tasks
    // -----------------------------------------------------------------
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    // Avalon access: hold everything until waitrequest is sampled low
    task automatic reg_acc(input logic wr, input logic [5:0] a, input logic [7:0] d);
        int n;
        n = 0;
        avsAddress <= a;
        avsWritedata <= {24'h0, d};
        avsWrite <= wr;
        avsRead <= !wr;
        @(posedge mclk);
        while (avsWaitrequest !== 1'b0 && n < 50) begin
            @(posedge mclk);
            n++;
        end
        rd = avsReaddata;
        if (n >= 50) chk("waitrequest", 1, 0);
        avsWrite <= 0;
        avsRead <= 0;
        @(posedge mclk);
    endtask : reg_acc
    // CPU access: lat counts edges from the taking edge to the acknowledge
    task automatic cpu_acc(input logic wr, input logic [23:0] a, input logic [15:0] d, input logic [1:0] be);
        cpuCmd <= '{write: wr, addr: a, wdata: d, byteEn: be};
        cpuReq <= 1;
        lat = 0;
        @(posedge mclk);
        while (cpuAck !== 1'b1 && lat < 100) begin
            @(posedge mclk);
            lat++;
        end
        cd = cpuRdata;
        if (lat >= 100) chk("cpuAck timeout", 1, 0);
        cpuReq <= 0;
        @(posedge mclk);
        repeat (4) @(posedge mclk);
    endtask : cpu_acc
    task automatic print_verdict;
        if (n_errors == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : print_verdict
    // -----------------------------------------------------------------
    // Tests
    // -----------------------------------------------------------------
    initial begin
        repeat (2) @(posedge mclk);
        reset <= 0;
        @(posedge mclk);
        for (int i = 0; i < DTW_NUM_REGS; i++) begin
            reg_acc(0, 6'(4 * i), 8'h00);
            chk("reset value", rd, {24'h0, DTW_REG_RESET[i]});
        end
        reg_acc(0, 6'h24, 8'h00);
        chk("unmapped read", rd, 0);
        // Area 2 set up as 16-bit DRAM, one wait, 2 Mbyte areas, refresh still off
        reg_acc(1, 6'h00, 8'h00);
        reg_acc(1, 6'h0c, 8'h10);
        reg_acc(1, 6'h10, 8'h01);
        reg_acc(1, 6'h14, 8'h04);
        reg_acc(1, 6'h18, 8'h54);
        reg_acc(1, 6'h20, 8'h4f);
        reg_acc(0, 6'h18, 8'h00);
        chk("mem ctrl rb", rd, 32'h54);
        cpu_acc(1, 24'h47fffe, 16'ha5c3, 2'b11);
        chk("row miss lat", lat, 5);
        chk("row addr", rowSeen, 24'h47fffe >> 9);
        chk("both we", weSeen, 2'b00);
        cpu_acc(1, 24'h47fffe, 16'h1111, 2'b01);
        chk("low we only", weSeen, 2'b10);
        chk("col addr", colSeen, 24'h47fffe);
        cpu_acc(0, 24'h47fffe, 16'h0000, 2'b11);
        chk("read merge", cd, 16'ha511);
        chk("ras up idle", dramPins.rasN, 1);
        // Area 1 lies just below the DRAM area; answered at once
        cpu_acc(0, 24'h3ffffe, 16'h0000, 2'b11);
        chk("outside lat", lat, 1);
        chk("outside data", cd, 0);
        // RAS down keeps the row open, so a same-row access is a page hit
        reg_acc(1, 6'h18, 8'h74);
        cpu_acc(0, 24'h47fffe, 16'h0000, 2'b11);
        cpu_acc(0, 24'h47fffe, 16'h0000, 2'b11);
        chk("page hit lat", lat, 4);
        chk("page hit data", cd, 16'ha511);
        chk("ras down idle", dramPins.rasN, 0);
        reg_acc(1, 6'h18, 8'h54);
        // Refresh on, divide-by-two prescale, interrupt masked
        reg_acc(1, 6'h1c, 8'h81);
        for (int i = 0; i < 600 && refT.size() < 2; i++) @(posedge mclk);
        chk("refresh count", refT.size() >= 2, 1);
        if (refT.size() >= 2) chk("refresh period", refT[1] - refT[0], 160);
        chk("precharge first", badPre, 0);
        reg_acc(0, 6'h1c, 8'h00);
        chk("match flag", rd[4], 1);
        chk("irq masked", cmIrq, 0);
        reg_acc(1, 6'h1c, 8'h89);
        repeat (170) @(posedge mclk);
        chk("irq unmasked", cmIrq, 1);
        cpu_acc(1, 24'h400000, 16'h5a5a, 2'b11);
        cpu_acc(0, 24'h400000, 16'h0000, 2'b11);
        chk("after refresh", cd, 16'h5a5a);
        print_verdict();
    end
    // Watchdog well beyond the few hundred cycles the tests need
    initial begin
        #200000;
        n_errors++;
        print_verdict();
    end
endmodule : dtw_dram_ctrl_tb_top
